// ===== hw/clk_speed_pkg.sv
package clk_speed_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [7:0]  CFG_REG_INDEX   = 8'h8f;   // special-function index of config
    localparam logic [7:0]  STAT_REG_INDEX  = 8'h90;   // status word of this block
    localparam logic [ADDR_W-1:0] CFG_REG_ADDR  = {2'h0, CFG_REG_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] STAT_REG_ADDR = {2'h0, STAT_REG_INDEX, 2'h0};

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int          DOUBLE_SPEED_BIT   = 0;
    localparam logic [7:0]  CFG_RESET_VALUE    = 8'h00;
    localparam int          STAT_MODE_BIT      = 0;
    localparam int          STAT_RESET_BIT     = 1;

    // ------------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------------
    localparam int          OSC_PER_MC_STD     = 12;
    localparam int          OSC_PER_MC_X2      = 6;
    localparam int          DIVIDER_RATIO      = OSC_PER_MC_STD / OSC_PER_MC_X2;
    localparam int          CORE_TICKS_PER_MC  = OSC_PER_MC_STD / DIVIDER_RATIO;
    localparam int          RESET_HOLD_MC      = 2;

    // ------------------------------------------------------------------
    // bus answers and types
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP    = 1'b1
    } wr_state_t;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rd_state_t;

    typedef struct packed {
        logic reset_active;
        logic double_speed_active;
    } clk_status_t;

endpackage

// ===== hw/core_clock_speed_select.sv
`timescale 1ns/100ps
`default_nettype none

module core_clock_speed_select
    import clk_speed_pkg::*;
#(
    parameter int MC_TICKS   = CORE_TICKS_PER_MC,
    parameter int RESET_MC   = RESET_HOLD_MC
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // crystal and reset pins
    input  wire logic              crystal_input,
    output logic                   crystal_output,
    input  wire logic              reset_pin,
    // clock and time bases toward cpu and peripherals
    output logic                   core_clock_out,
    output logic                   core_tick,
    output logic                   machine_cycle_tick,
    output logic                   chip_reset,
    output clk_status_t            status,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // decode a byte address to a mapped register
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] reg_addr);
        addr_is = (a[ADDR_W-1:2] == reg_addr[ADDR_W-1:2]);
    endfunction

    // wrap counter step
    function automatic logic [3:0] wrap_inc(input logic [3:0] v, input int top);
        wrap_inc = (v == 4'(top - 1)) ? 4'h0 : v + 4'h1;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    logic [1:0] pins_sync;
    logic       xtal_s;
    logic       rst_pin_s;

    sync_two_ff #(
        .WIDTH    (2)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({reset_pin, crystal_input}),
        .sync_out (pins_sync)
    );

    assign xtal_s    = pins_sync[0];
    assign rst_pin_s = pins_sync[1];

    // ------------------------------------------------------------------
    // crystal edge and divide-by-two stage
    // ------------------------------------------------------------------
    logic xtal_prev_reg;
    logic div2_reg;
    logic xtal_rise;
    logic div2_rise;

    assign xtal_rise = xtal_s & ~xtal_prev_reg;
    assign div2_rise = xtal_rise & ~div2_reg;

    // crystal edge history
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            xtal_prev_reg <= 1'b0;
        end else begin
            xtal_prev_reg <= xtal_s;
        end
    end

    // divider toggles on every crystal rising edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div2_reg <= 1'b0;
        end else if (xtal_rise) begin
            div2_reg <= ~div2_reg;
        end
    end

    // inverting amplifier output
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            crystal_output <= 1'b1;
        end else begin
            crystal_output <= ~xtal_s;
        end
    end

    // ------------------------------------------------------------------
    // configuration and mode switch
    // ------------------------------------------------------------------
    logic [7:0] clock_config_reg;
    logic       double_speed_select;
    logic       mode_active_reg;
    logic       cfg_write;
    logic [7:0] cfg_wbyte;

    assign double_speed_select = clock_config_reg[DOUBLE_SPEED_BIT];

    // software byte write; full chip reset returns to standard mode
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clock_config_reg <= CFG_RESET_VALUE;
        end else if (chip_reset) begin
            clock_config_reg <= CFG_RESET_VALUE;
        end else if (cfg_write) begin
            clock_config_reg <= {7'h00, cfg_wbyte[DOUBLE_SPEED_BIT]};
        end
    end

    // mode taken only on divided clock rising edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_active_reg <= 1'b0;
        end else if (div2_rise) begin
            mode_active_reg <= double_speed_select;
        end
    end

    // ------------------------------------------------------------------
    // core clock selection and time bases
    // ------------------------------------------------------------------
    logic       core_rise;
    logic [3:0] mc_cnt_reg;
    logic       mc_wrap;

    // x2: every crystal rising edge; std: every second one
    assign core_rise = mode_active_reg ? xtal_rise : div2_rise;
    assign mc_wrap   = core_rise && (mc_cnt_reg == 4'(MC_TICKS - 1));

    // selected clock toward cpu and peripherals
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            core_clock_out <= 1'b0;
            core_tick      <= 1'b0;
        end else begin
            core_clock_out <= mode_active_reg ? xtal_s : div2_reg;
            core_tick      <= core_rise;
        end
    end

    // six core periods per machine cycle in both modes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mc_cnt_reg <= 4'h0;
        end else if (core_rise) begin
            mc_cnt_reg <= wrap_inc(mc_cnt_reg, MC_TICKS);
        end
    end

    // machine cycle strobe for cpu and peripheral timers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            machine_cycle_tick <= 1'b0;
        end else begin
            machine_cycle_tick <= mc_wrap;
        end
    end

    // ------------------------------------------------------------------
    // reset pin qualification
    // ------------------------------------------------------------------
    logic [3:0] rst_mc_reg;

    // count machine cycles while the pin stays high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_mc_reg <= 4'h0;
        end else if (!rst_pin_s) begin
            rst_mc_reg <= 4'h0;
        end else if (mc_wrap && rst_mc_reg != 4'(RESET_MC)) begin
            rst_mc_reg <= rst_mc_reg + 4'h1;
        end
    end

    // full reset while qualified pin stays high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            chip_reset <= 1'b0;
        end else begin
            chip_reset <= rst_pin_s && (rst_mc_reg == 4'(RESET_MC));
        end
    end

    // status word for peripherals and readback
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
        end else begin
            status.double_speed_active <= mode_active_reg;
            status.reset_active        <= chip_reset;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    wr_state_t         wr_state_reg;
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              aw_take;
    logic              w_take;
    logic              both_held;

    assign aw_take   = s_axi_awvalid & s_axi_awready;
    assign w_take    = s_axi_wvalid & s_axi_wready;
    assign both_held = aw_held_reg & w_held_reg;
    assign cfg_write = (wr_state_reg == WR_COLLECT) && both_held
                       && addr_is(awaddr_reg, CFG_REG_ADDR) && wstrb_reg[0];
    assign cfg_wbyte = wdata_reg[7:0];

    // address and data captured in either order
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= 32'h0;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (wr_state_reg == WR_COLLECT && both_held) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (wr_state_reg == WR_COLLECT && both_held) begin
                w_held_reg <= 1'b0;
            end
            s_axi_awready <= (wr_state_reg == WR_COLLECT) && !aw_held_reg && !aw_take
                             && !both_held;
            s_axi_wready  <= (wr_state_reg == WR_COLLECT) && !w_held_reg && !w_take
                             && !both_held;
        end
    end

    // response after both halves arrived
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_state_reg <= WR_COLLECT;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            case (wr_state_reg)
                WR_COLLECT: begin
                    if (both_held) begin
                        wr_state_reg <= WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= (addr_is(awaddr_reg, CFG_REG_ADDR)
                                         || addr_is(awaddr_reg, STAT_REG_ADDR))
                                        ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_reg <= WR_COLLECT;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_reg <= WR_COLLECT;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    rd_state_t rd_state_reg;

    // one read at a time, data one cycle after address
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_state_reg  <= RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            case (rd_state_reg)
                RD_IDLE: begin
                    s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
                    if (s_axi_arvalid && s_axi_arready) begin
                        rd_state_reg <= RD_DATA;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp  <= RESP_OKAY;
                        if (addr_is(s_axi_araddr, CFG_REG_ADDR)) begin
                            s_axi_rdata <= {24'h0, clock_config_reg};
                        end else if (addr_is(s_axi_araddr, STAT_REG_ADDR)) begin
                            s_axi_rdata <= {30'h0, status};
                        end else begin
                            s_axi_rdata <= 32'h0;
                            s_axi_rresp <= RESP_SLVERR;
                        end
                    end
                end
                RD_DATA: begin
                    s_axi_arready <= 1'b0;
                    if (s_axi_rready) begin
                        rd_state_reg  <= RD_IDLE;
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
                default: begin
                    rd_state_reg <= RD_IDLE;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

endmodule // core_clock_speed_select

`default_nettype wire

// ===== hw/sync_two_ff.sv
`timescale 1ns/100ps
`default_nettype none

module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // two flops, first one read only by second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule // sync_two_ff

`default_nettype wire

// ===== test/core_clock_speed_select_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module core_clock_speed_select_monitor
    import clk_speed_pkg::*;
#(
    parameter int MC_TICKS = CORE_TICKS_PER_MC,
    parameter int RESET_MC = RESET_HOLD_MC
) (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        crystal_input,
    input wire logic        reset_pin,
    input wire logic        core_tick,
    input wire logic        machine_cycle_tick,
    input wire logic        chip_reset,
    input wire clk_status_t status,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic [4:0] tick_cnt;
    logic       mc_seen;
    logic       cry_q;
    logic [3:0] since_rise;
    logic [3:0] pin_mc_cnt;

    // core ticks inside the running machine cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= 5'h00;
            mc_seen  <= 1'b0;
        end else if (chip_reset || machine_cycle_tick) begin
            tick_cnt <= 5'h00;
            mc_seen  <= !chip_reset;
        end else begin
            tick_cnt <= tick_cnt + 5'(core_tick);
        end
    end

    // cycles since the last crystal rise, saturating
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cry_q      <= 1'b0;
            since_rise <= 4'hf;
        end else begin
            cry_q      <= crystal_input;
            since_rise <= (crystal_input && !cry_q) ? 4'h0 : since_rise + 4'(since_rise != 4'hf);
        end
    end

    // machine cycles seen while the reset pin is high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_mc_cnt <= 4'h0;
        end else if (!reset_pin) begin
            pin_mc_cnt <= 4'h0;
        end else begin
            pin_mc_cnt <= pin_mc_cnt + 4'(machine_cycle_tick && pin_mc_cnt != 4'hf);
        end
    end

    property p_tick_pulse;
        core_tick |=> !core_tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("core tick wider than one cycle");

    property p_mc_spacing;
        machine_cycle_tick && mc_seen |-> (tick_cnt + 5'(core_tick)) == 5'(MC_TICKS);
    endproperty
    a_mc_spacing: assert property (p_mc_spacing)
        else $error("wrong core tick count per machine cycle");

    property p_mode_change;
        $changed(status.double_speed_active) |-> since_rise <= 4'h7;
    endproperty
    a_mode_change: assert property (p_mode_change)
        else $error("mode changed away from a crystal rise");

    property p_reset_qual;
        $rose(chip_reset) |-> pin_mc_cnt >= 4'(RESET_MC);
    endproperty
    a_reset_qual: assert property (p_reset_qual)
        else $error("chip reset before two machine cycles");

    property p_reset_hold;
        chip_reset && reset_pin |=> chip_reset;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("chip reset dropped while pin high");

    property p_aw_refused;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_aw_refused: assert property (p_aw_refused)
        else $error("write address accepted with response pending");

    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once)
        else $error("write response repeated");

    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once)
        else $error("read data repeated");

    property p_rdata_zero;
        s_axi_rvalid |-> s_axi_rdata[31:2] == 30'h0;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero)
        else $error("unused read bits not zero");
endmodule // core_clock_speed_select_monitor

bind core_clock_speed_select core_clock_speed_select_monitor #(
    .MC_TICKS(MC_TICKS),
    .RESET_MC(RESET_MC)
) mon_u (
    .core_clk, .rstn, .crystal_input, .reset_pin, .core_tick, .machine_cycle_tick,
    .chip_reset, .status, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

`default_nettype wire

// ===== test/crystal_source_model.sv
`timescale 1ns/100ps
`default_nettype none

module crystal_source_model #(
    parameter realtime HALF_NS = 47.2
) (
    output var logic osc_out
);
    // free-running oscillator; half period never lands on a core_clk rising edge
    initial begin
        osc_out = 1'b0;
        forever begin
            #(HALF_NS) osc_out = !osc_out;
        end
    end
endmodule // crystal_source_model

`default_nettype wire

// ===== test/test_core_clock_speed_select.sv
`timescale 1ns/100ps
`default_nettype none

module test_core_clock_speed_select
    import clk_speed_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              rstn = 1'b0;
    logic              reset_pin = 1'b0;
    logic              crystal_input;
    logic              crystal_output;
    logic              core_clock_out;
    logic              core_tick;
    logic              machine_cycle_tick;
    logic              chip_reset;
    clk_status_t       status;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0;
    logic [31:0]       s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'h1;
    logic [1:0]        s_axi_bresp;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0;
    logic              s_axi_awready;
    logic              s_axi_wready;
    logic              s_axi_bvalid;
    logic              s_axi_arready;
    logic              s_axi_rvalid;
    logic              cry_q = 1'b0;
    logic              xo_q = 1'b1;
    logic              cco_q = 1'b0;
    int                num_errors = 0;
    int                samples_checked = 0;

    always #5 core_clk = !core_clk;
    always @(posedge core_clk) cry_q <= crystal_input;
    always @(posedge core_clk) xo_q <= crystal_output;
    always @(posedge core_clk) cco_q <= core_clock_out;

    crystal_source_model osc_u (.osc_out(crystal_input));

    core_clock_speed_select dut_u (
        .core_clk, .rstn, .crystal_input, .crystal_output, .reset_pin,
        .core_clock_out, .core_tick, .machine_cycle_tick, .chip_reset, .status,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    // ----
    // shared tasks
    // ----
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 200) begin
            @(posedge core_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) r = s_axi_bresp;
            if (s_axi_bvalid) s_axi_bready <= 1'b0;
            done = s_axi_bvalid;
        end
        check(32'(done), 32'h1);
        repeat (2) @(posedge core_clk);
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 200) begin
            @(posedge core_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) d = s_axi_rdata;
            if (s_axi_rvalid) r = s_axi_rresp;
            if (s_axi_rvalid) s_axi_rready <= 1'b0;
            done = s_axi_rvalid;
        end
        check(32'(done), 32'h1);
        repeat (2) @(posedge core_clk);
    endtask

    // crystal rises and core ticks over one whole machine cycle
    task automatic measure(input int exp_rises);
        int n;
        int rises;
        int ticks;
        int clk_rises;
        int xo_falls;
        n = 0;
        rises = 0;
        ticks = 0;
        clk_rises = 0;
        xo_falls = 0;
        do @(posedge core_clk); while (!machine_cycle_tick && ++n < 2000);
        do begin
            @(posedge core_clk);
            n++;
            rises += int'(crystal_input && !cry_q);
            ticks += int'(core_tick);
            clk_rises += int'(core_clock_out && !cco_q);
            xo_falls += int'(!crystal_output && xo_q);
        end while (!machine_cycle_tick && n < 4000);
        check(rises, exp_rises);
        check(ticks, CORE_TICKS_PER_MC);
        check(clk_rises, CORE_TICKS_PER_MC);
        check(xo_falls, exp_rises);
    endtask

    task automatic wait_mode(input logic v);
        int n;
        n = 0;
        while (status.double_speed_active !== v && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        check(32'(status.double_speed_active), 32'(v));
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset_values();
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(CFG_REG_ADDR, d, r);
        check(d, 32'(CFG_RESET_VALUE));
        check(32'(r), 32'(RESP_OKAY));
        axi_read(STAT_REG_ADDR, d, r);
        check(d, 32'h0);
        measure(OSC_PER_MC_STD);
    endtask

    task automatic t_speed_switch();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(CFG_REG_ADDR, 32'h1, r);
        check(32'(r), 32'(RESP_OKAY));
        axi_read(CFG_REG_ADDR, d, r);
        check(d, 32'h1);
        wait_mode(1'b1);
        measure(OSC_PER_MC_X2);
        axi_write(CFG_REG_ADDR, 32'h0, r);
        wait_mode(1'b0);
        measure(OSC_PER_MC_STD);
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(12'h08c, 32'h1, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(12'h08c, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(RESP_SLVERR));
        axi_write(STAT_REG_ADDR, 32'h1, r);
        check(32'(r), 32'(RESP_OKAY));
        s_axi_wstrb <= 4'h0;
        axi_write(CFG_REG_ADDR, 32'h1, r);
        check(32'(r), 32'(RESP_OKAY));
        s_axi_wstrb <= 4'h1;
        axi_read(CFG_REG_ADDR, d, r);
        check(d, 32'h0);
    endtask

    task automatic t_reset_pin();
        logic [31:0] d;
        logic [1:0]  r;
        logic        seen;
        int          n;
        seen = 1'b0;
        n = 0;
        axi_write(CFG_REG_ADDR, 32'h1, r);
        wait_mode(1'b1);
        @(posedge core_clk) reset_pin <= 1'b1;
        repeat (40) @(posedge core_clk) seen |= chip_reset;
        reset_pin <= 1'b0;
        repeat (10) @(posedge core_clk) seen |= chip_reset;
        check(32'(seen), 32'h0);
        reset_pin <= 1'b1;
        while (chip_reset !== 1'b1 && n < 400) @(posedge core_clk) n++;
        repeat (2) @(posedge core_clk);
        check(32'(chip_reset), 32'h1);
        check(32'(status.reset_active), 32'h1);
        wait_mode(1'b0);
        reset_pin <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(32'(chip_reset), 32'h0);
        axi_read(CFG_REG_ADDR, d, r);
        check(d, 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_values();
        t_speed_switch();
        t_unmapped();
        t_reset_pin();
        end_sim();
    end

    // watchdog against a hung handshake
    initial begin
        #200us;
        num_errors++;
        end_sim();
    end
endmodule // test_core_clock_speed_select

`default_nettype wire
